// file: rtl/psci_pkg.sv
// package: register map, timing constants and types of the power and chain-id controller
package psci_pkg;
  // ==========================================
  // apb register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] CHAIN_OFF = 8'h08;
  localparam logic [7:0] SDIV_OFF = 8'h0C;
  // ==========================================
  // control register fields
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_PDN_BIT = 1;
  localparam int CTRL_WAKE_BIT = 2;
  localparam int CTRL_CLKEN_BIT = 3;
  // ==========================================
  // device serial map
  localparam logic [7:0] PWR_MGMT_ADDR = 8'h03;
  localparam logic [7:0] WAKE_VALUE = 8'h01;
  localparam logic [7:0] SBW_OPCODE = 8'hA5;
  // ==========================================
  // serial timing in serial clock cycles; SDIV_RESET is the half period in core clock cycles
  localparam int PRE_PULSES = 4;
  localparam int RST_HIGH_CYC = 2;
  localparam int CHAIN_MAX = 63;
  localparam int SBW_BITS = 24;
  localparam logic [15:0] SDIV_RESET = 16'h0004;
  // ==========================================
  // states and pin bundle
  typedef enum logic [2:0] {
    PSCI_IDLE = 3'b000,
    PSCI_PRE = 3'b001,
    PSCI_RSTHI = 3'b010,
    PSCI_COUNT = 3'b011,
    PSCI_SBW = 3'b100,
    PSCI_DONE = 3'b101
  } psci_state_t;
  typedef struct packed {
    logic rst;
    logic cmd;
    logic sck;
  } psci_serial_t;
endpackage : psci_pkg

// file: rtl/psci_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module psci_sync (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // low-true pins idle high, so reset to that level to avoid a false edge
      meta_reg <= 1'b1;
      o_q <= 1'b1;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule : psci_sync

// file: rtl/psci_sck_gen.sv
// serial clock divider: produces the serial clock level and fall ticks
`timescale 1ns/100ps
module psci_sck_gen (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [15:0] i_half,
  output logic o_sck,
  output logic o_fall
);
  logic [15:0] cnt_reg;
  logic tick;
  assign tick = i_run && (cnt_reg >= i_half - 16'h0001);
  assign o_fall = i_ce && tick && o_sck;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 16'h0000;
      o_sck <= 1'b0;
    end else if (i_ce) begin
      if (!i_run) begin
        cnt_reg <= 16'h0000;
        o_sck <= 1'b0;
      end else if (tick) begin
        cnt_reg <= 16'h0000;
        o_sck <= ~o_sck;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule : psci_sck_gen

// file: rtl/psci_ctrl.sv
// host controller for serial chain identification, powerdown entry and wake
`timescale 1ns/100ps
module psci_ctrl #(
  parameter int CNT_W = 6,
  parameter logic [15:0] SDIV_DEF = psci_pkg::SDIV_RESET
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_host_chain_return,
  output logic o_serial_reset_line,
  output logic o_serial_command_line,
  output logic o_serial_clock,
  output logic o_request_clock_en,
  output logic o_powerdown_req,
  output logic o_busy
);
  // ==========================================
  // registers and wires
  psci_pkg::psci_state_t state_reg;
  psci_pkg::psci_serial_t ser_reg;
  logic [15:0] sdiv_reg;
  logic clken_reg;
  logic pdn_reg;
  logic init_go;
  logic wake_go;
  logic chain_s;
  logic chain_one;
  logic sck_fall;
  logic sck_level;
  logic [5:0] step_reg;
  logic [CNT_W-1:0] pos_reg;
  logic [CNT_W-1:0] id_reg;
  logic id_valid_reg;
  logic chain_seen_one_reg;
  logic [23:0] shift_reg;
  logic wr_acc;
  logic rd_acc;
  logic run;
  // ==========================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite && i_ce;
  assign rd_acc = psel && penable && !pwrite;
  assign pslverr = psel && penable && !(paddr == psci_pkg::CTRL_OFF ||
    paddr == psci_pkg::STAT_OFF || paddr == psci_pkg::CHAIN_OFF ||
    paddr == psci_pkg::SDIV_OFF);
  assign init_go = wr_acc && paddr == psci_pkg::CTRL_OFF &&
    pwdata[psci_pkg::CTRL_INIT_BIT] && state_reg == psci_pkg::PSCI_IDLE;
  assign wake_go = wr_acc && paddr == psci_pkg::CTRL_OFF &&
    pwdata[psci_pkg::CTRL_WAKE_BIT] && state_reg == psci_pkg::PSCI_IDLE;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sdiv_reg <= SDIV_DEF;
      clken_reg <= 1'b1;
      pdn_reg <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == psci_pkg::SDIV_OFF && pwdata[15:0] != 16'h0000) begin
        sdiv_reg <= pwdata[15:0];
      end
      if (paddr == psci_pkg::CTRL_OFF) begin
        // the request clock gate is software's, and stopping it waits on timing it owns
        clken_reg <= pwdata[psci_pkg::CTRL_CLKEN_BIT];
        // refresh bursts around entry and exit stay with software, gated by these levels
        pdn_reg <= pwdata[psci_pkg::CTRL_PDN_BIT];
      end
    end
  end
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      case (paddr)
        psci_pkg::CTRL_OFF: begin
          prdata[psci_pkg::CTRL_PDN_BIT] = pdn_reg;
          prdata[psci_pkg::CTRL_CLKEN_BIT] = clken_reg;
        end
        psci_pkg::STAT_OFF: prdata[3:0] = {id_valid_reg, 3'(state_reg)} ^ 4'h0;
        psci_pkg::CHAIN_OFF: prdata[CNT_W-1:0] = id_reg;
        psci_pkg::SDIV_OFF: prdata[15:0] = sdiv_reg;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
  assign o_request_clock_en = clken_reg;
  assign o_powerdown_req = pdn_reg;
  // ==========================================
  // pins: chain return is asynchronous, serial clock from divider
  psci_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_d(i_host_chain_return),
    .o_q(chain_s)
  );
  // return pin is low true: pin low means a logical one
  assign chain_one = ~chain_s;
  assign run = state_reg != psci_pkg::PSCI_IDLE && state_reg != psci_pkg::PSCI_DONE;
  psci_sck_gen u_sck (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_run(run),
    .i_half(sdiv_reg),
    .o_sck(sck_level),
    .o_fall(sck_fall)
  );
  // lines are low true at the pin, so a logical one drives low
  assign o_serial_clock = ~sck_level;
  assign o_serial_reset_line = ~ser_reg.rst;
  assign o_serial_command_line = ~ser_reg.cmd;
  // ==========================================
  // sequencer: device samples on falling serial clock, so host changes there too
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= psci_pkg::PSCI_IDLE;
      ser_reg <= '0;
      step_reg <= 6'h00;
      shift_reg <= 24'h000000;
    end else if (i_ce) begin
      case (state_reg)
        psci_pkg::PSCI_IDLE: begin
          ser_reg <= '0;
          step_reg <= 6'h00;
          if (init_go) begin
            state_reg <= psci_pkg::PSCI_PRE;
          end else if (wake_go) begin
            shift_reg <= {psci_pkg::SBW_OPCODE, psci_pkg::PWR_MGMT_ADDR,
              psci_pkg::WAKE_VALUE};
            state_reg <= psci_pkg::PSCI_SBW;
          end
        end
        psci_pkg::PSCI_PRE: if (sck_fall) begin
          step_reg <= step_reg + 6'h01;
          if (step_reg == 6'(psci_pkg::PRE_PULSES - 1)) begin
            ser_reg.rst <= 1'b1;
            step_reg <= 6'h00;
            state_reg <= psci_pkg::PSCI_RSTHI;
          end
        end
        psci_pkg::PSCI_RSTHI: if (sck_fall) begin
          step_reg <= step_reg + 6'h01;
          // hold past the minimum so the chain has settled to one
          if (step_reg == 6'(psci_pkg::RST_HIGH_CYC + 2)) begin
            ser_reg.rst <= 1'b0;
            step_reg <= 6'h00;
            state_reg <= psci_pkg::PSCI_COUNT;
          end
        end
        psci_pkg::PSCI_COUNT: if (sck_fall) begin
          if (chain_seen_one_reg && !chain_one) begin
            state_reg <= psci_pkg::PSCI_DONE;
          end else if (step_reg == 6'(psci_pkg::CHAIN_MAX)) begin
            state_reg <= psci_pkg::PSCI_DONE;
          end else begin
            step_reg <= step_reg + 6'h01;
          end
        end
        psci_pkg::PSCI_SBW: if (sck_fall) begin
          ser_reg.cmd <= shift_reg[23];
          shift_reg <= {shift_reg[22:0], 1'b0};
          step_reg <= step_reg + 6'h01;
          if (step_reg == 6'(psci_pkg::SBW_BITS)) begin
            ser_reg.cmd <= 1'b0;
            state_reg <= psci_pkg::PSCI_DONE;
          end
        end
        psci_pkg::PSCI_DONE: begin
          ser_reg <= '0;
          state_reg <= psci_pkg::PSCI_IDLE;
        end
        default: state_reg <= psci_pkg::PSCI_IDLE;
      endcase
    end
  end
  // ==========================================
  // chain position measurement: counts falling edges after reset low
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pos_reg <= '0;
      id_reg <= '0;
      id_valid_reg <= 1'b0;
      chain_seen_one_reg <= 1'b0;
    end else if (i_ce) begin
      if (init_go) begin
        pos_reg <= '0;
        id_valid_reg <= 1'b0;
        chain_seen_one_reg <= 1'b0;
      end else if (sck_fall) begin
        if (state_reg == psci_pkg::PSCI_RSTHI && chain_one) begin
          chain_seen_one_reg <= 1'b1;
        end
        if (state_reg == psci_pkg::PSCI_COUNT) begin
          if (chain_seen_one_reg && !chain_one) begin
            id_reg <= pos_reg;
            id_valid_reg <= 1'b1;
          end else if (pos_reg != {CNT_W{1'b1}}) begin
            pos_reg <= pos_reg + CNT_W'(1);
          end
        end
      end
    end
  end
  assign o_busy = run;
endmodule : psci_ctrl

// file: dv/psci_ctrl_sva.sv
// checker: port assertions of the power and chain-id controller
`timescale 1ns/100ps
module psci_ctrl_chk (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic o_serial_reset_line,
  input wire logic o_serial_command_line,
  input wire logic o_serial_clock,
  input wire logic o_request_clock_en,
  input wire logic o_powerdown_req,
  input wire logic o_busy
);
  // ==========
  // pins are low true: a falling clock pin is a rising serial clock
  logic [3:0] np;
  logic sq;
  logic wr;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  assign wr = psel & penable & pwrite & (paddr == psci_pkg::CTRL_OFF);
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      np <= 4'h0;
      sq <= 1'b1;
    end else begin
      sq <= o_serial_clock;
      if (!o_busy || !o_serial_reset_line) np <= 4'h0;
      else if (sq && !o_serial_clock) np <= np + 4'h1;
    end
  end
  AST_CMD_ZERO: assert property (!o_serial_reset_line |-> o_serial_command_line)
    else $error("command active in reset");
  AST_RST_HOLD: assert property ($fell(o_serial_reset_line) |->
    !o_serial_reset_line [*8] ##1 !o_serial_reset_line [*8])
    else $error("reset too short");
  AST_PRE_PULSES: assert property ($fell(o_serial_reset_line) |-> np == 4'h4)
    else $error("wrong pulse count");
  AST_SCK_IDLE: assert property (!o_busy [*8] |-> o_serial_clock)
    else $error("clock runs when idle");
  AST_PDN_LEVEL: assert property (wr |=> o_powerdown_req == $past(pwdata[1]))
    else $error("powerdown level wrong");
  AST_CLKEN_LEVEL: assert property (wr |=> o_request_clock_en == $past(pwdata[3]))
    else $error("clock enable wrong");
  AST_INIT_GO: assert property (wr && pwdata[0] && !o_busy |=> o_busy)
    else $error("init not started");
  AST_WAKE_BIT: assert property (wr && pwdata[2] && !pwdata[0] && !o_busy |=>
    o_busy ##[1:40] !o_serial_command_line)
    else $error("wake frame missing");
endmodule : psci_ctrl_chk
bind psci_ctrl psci_ctrl_chk u_chk (
  .i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .o_serial_reset_line(o_serial_reset_line),
  .o_serial_command_line(o_serial_command_line),
  .o_serial_clock(o_serial_clock),
  .o_request_clock_en(o_request_clock_en),
  .o_powerdown_req(o_powerdown_req),
  .o_busy(o_busy)
);

// file: dv/psci_dev_model.sv
// model: chain of devices on the serial bus, with power state
`timescale 1ns/100ps
module psci_dev_model #(
  parameter int K = 5
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_n,
  input wire logic i_sck_n,
  input wire logic i_pdn,
  output logic o_ret_n,
  output logic o_asleep
);
  // ==========
  // far chain input terminated to logical zero
  logic [K-1:0] dout = '0;
  logic [K-1:0] in_s = '0;
  logic rst_q = 1'b0;
  logic cmd_q = 1'b0;
  logic rst_s = 1'b0;
  logic [23:0] sr = '0;
  logic [13:0] rfsh = '0;
  wire [K:0] link = {dout, 1'b0};
  assign o_ret_n = ~link[K];
  initial o_asleep = 1'b0;
  // lines are latched half a core cycle early: the host moves them on the sampling edge
  always @(negedge i_core_clk) begin
    rst_q <= ~i_rst_n;
    cmd_q <= ~i_cmd_n;
  end
  // logical falling serial clock: every device samples here
  always @(posedge i_sck_n) begin
    rst_s <= rst_q;
    in_s <= link[K-1:0];
    sr <= {sr[22:0], cmd_q};
  end
  // outputs move half a cycle later, so the next device sees them on the next fall
  always @(negedge i_sck_n) dout <= {K{rst_s}} | (in_s & dout);
  always @(posedge i_pdn) o_asleep <= 1'b1;
  always @(sr) begin
    if (sr == {psci_pkg::SBW_OPCODE, psci_pkg::PWR_MGMT_ADDR, psci_pkg::WAKE_VALUE})
      o_asleep <= 1'b0;
  end
  // low 3 bits pick the bank, the carry steps the row
  always @(posedge i_core_clk) if (o_asleep) rfsh <= rfsh + 14'h1;
endmodule : psci_dev_model

// file: dv/testbench.sv
// testbench: apb-driven checks of the power and chain-id controller
`timescale 1ns/100ps
module testbench;
  // ==========
  // signals
  localparam int K = 5;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, i_host_chain_return, o_serial_reset_line, o_serial_command_line;
  logic o_serial_clock, o_request_clock_en, o_powerdown_req, o_busy, asleep;
  logic [32:0] exp_q[$];
  logic [31:0] rnd = 32'h153D;
  logic [15:0] sd = psci_pkg::SDIV_RESET;
  int fails = 0;
  int num_checks = 0;
  always #5 i_core_clk = ~i_core_clk;
  psci_ctrl i_dut (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .i_host_chain_return(i_host_chain_return),
    .o_serial_reset_line(o_serial_reset_line),
    .o_serial_command_line(o_serial_command_line),
    .o_serial_clock(o_serial_clock),
    .o_request_clock_en(o_request_clock_en),
    .o_powerdown_req(o_powerdown_req),
    .o_busy(o_busy)
  );
  psci_dev_model #(.K(K)) i_model (.i_core_clk(i_core_clk), .i_rst_n(o_serial_reset_line),
    .i_cmd_n(o_serial_command_line), .i_sck_n(o_serial_clock), .i_pdn(o_powerdown_req),
    .o_ret_n(i_host_chain_return), .o_asleep(asleep));
  // ==========
  // tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1) @(posedge i_core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_core_clk);
  endtask : apb
  task automatic idle;
    repeat (2) @(posedge i_core_clk);
    while (o_busy !== 1'b0) @(posedge i_core_clk);
  endtask : idle
  task automatic report_and_stop;
    if (exp_q.size() != 0) fails++;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ==========
  // read results are compared against the oldest note
  always @(posedge i_core_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
      chk(exp_q.pop_front(), {pslverr, pslverr ? 32'h0 : prdata});
  end
  initial begin
    repeat (30000) @(posedge i_core_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    apb(1'b0, psci_pkg::SDIV_OFF, 32'h0, {17'h0, sd});
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    $display("test reset done");
    apb(1'b1, psci_pkg::CTRL_OFF, 32'h9, 33'h0);
    idle();
    apb(1'b0, psci_pkg::CHAIN_OFF, 32'h0, 33'(K));
    apb(1'b0, psci_pkg::STAT_OFF, 32'h0, 33'h8);
    $display("test chain done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      if (i == 3) rnd = 32'h0;
      if (rnd[15:0] != 16'h0) sd = rnd[15:0];
      apb(1'b1, psci_pkg::SDIV_OFF, rnd, 33'h0);
      apb(1'b0, psci_pkg::SDIV_OFF, 32'h0, {17'h0, sd});
    end
    apb(1'b1, psci_pkg::SDIV_OFF, 32'h4, 33'h0);
    $display("test divider done");
    apb(1'b1, psci_pkg::CTRL_OFF, 32'hA, 33'h0);
    apb(1'b1, psci_pkg::CTRL_OFF, 32'h2, 33'h0);
    apb(1'b0, psci_pkg::CTRL_OFF, 32'h0, 33'h2);
    repeat (50) @(posedge i_core_clk);
    chk(33'h1, {32'h0, asleep});
    apb(1'b1, psci_pkg::CTRL_OFF, 32'hE, 33'h0);
    idle();
    repeat (20) @(posedge i_core_clk);
    chk(33'h0, {32'h0, asleep});
    apb(1'b1, psci_pkg::CTRL_OFF, 32'h8, 33'h0);
    apb(1'b0, psci_pkg::CTRL_OFF, 32'h0, 33'h8);
    $display("test power done");
    report_and_stop();
  end
endmodule : testbench
